/* File: core/usdp_fifo.sv */
// small synchronous fifo with a registered head word
`timescale 1ns/1ps
module usdp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   output logic                  outValid,
   output logic      [WIDTH-1:0] outData,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic [AW-1:0]    rdNext;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign inReady  = (count != FULL_COUNT);
   assign outValid = (count != '0);
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;
   assign rdNext   = AW'(rdPtr + 1'b1);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else if (flush) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wrPtr <= AW'(wrPtr + 1'b1);
         end
         if (pop) begin
            rdPtr <= rdNext;
         end
         if (push && !pop) begin
            count <= (AW+1)'(count + 1'b1);
         end else if (pop && !push) begin
            count <= (AW+1)'(count - 1'b1);
         end
      end
   end

   // head kept in a register so readers never see the array directly
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         outData <= '0;
      end else if (flush) begin
         outData <= '0;
      end else if (push && (count == '0 || (pop && count == 1))) begin
         outData <= inData;
      end else if (pop && count > 1) begin
         outData <= mem[rdNext];
      end
   end
endmodule

/* File: core/usdp_pkg.sv */
// constants shared by the shadow data port and its fifo
package usdp_pkg;
   // register map, byte addresses on the apb
   localparam logic [31:0] ALIAS_BASE  = 32'h5000_1130;
   localparam logic [31:0] ALIAS_14    = 32'h5000_1168;
   localparam int          ALIAS_COUNT = 16;
   localparam logic [31:0] ALIAS_SPAN  = 32'h0000_0040;
   localparam logic [31:0] CTRL_ADDR   = 32'h5000_1190;
   localparam logic [31:0] STATUS_ADDR = 32'h5000_1194;

   // widths and depths
   localparam int DATA_W     = 8;
   localparam int FIFO_DEPTH = 16;

   // control register fields
   localparam int CTRL_FIFO_EN = 0;
   localparam int CTRL_IR_MODE = 1;

   // status register fields
   localparam int STAT_RX_READY  = 0;
   localparam int STAT_OVERRUN   = 1;
   localparam int STAT_RX_FULL   = 2;
   localparam int STAT_TX_EMPTY  = 5;
   localparam int STAT_TX_FULL   = 6;

   // reset values
   localparam logic [31:0] DATA_RESET = 32'h0000_0000;
   localparam logic        CTRL_FIFO_EN_RESET = 1'b0;
   localparam logic        CTRL_IR_MODE_RESET = 1'b0;
endpackage

/* File: core/usdp_shadow_port.sv */
// shadow receive/transmit data port of the uart on an apb slave
//
// Operation
// - sixteen word aliases share one data path
// - no fifo: read returns latest received byte; either mode: input chosen by ir mode
// - no fifo: new byte overwrites, flags overrun
// - fifo mode: read returns head, pops it
// - full receive fifo drops byte, flags overrun
// - write sends byte to serial or infrared
// - no fifo: one write clears holding empty
// - no fifo: later writes replace held byte
// - fifo mode holds sixteen bytes plus one in the output stage before full
// - write to full transmit fifo is dropped
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module usdp_shadow_port (
   input  wire logic        clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // receive characters from the serial and infrared deserialisers
   input  wire logic        rxSerialValid,
   input  wire logic [7:0]  rxSerialData,
   input  wire logic        rxIrValid,
   input  wire logic [7:0]  rxIrData,
   // character handed to the transmit shifter
   output logic             txCharValid,
   output logic      [7:0]  txCharData,
   input  wire logic        txCharReady,
   // mode and status towards the rest of the uart
   output logic             irMode,
   output logic             fifoEnable,
   output logic             rxDataReady,
   output logic             txHoldingEmpty,
   output logic             overrunError
);
   localparam int DW = usdp_pkg::DATA_W;

   // bus decode
   logic [31:0]   aliasOffset;
   logic          isAlias;
   logic          isCtrl;
   logic          isStatus;
   logic          access;
   logic          dataRead;
   logic          dataWrite;
   logic          ctrlWrite;
   logic          statusRead;

   // receive path
   logic          rxValid;
   logic [DW-1:0] rxData;
   logic [DW-1:0] rxHold;
   logic          rxHoldFull;
   logic          rxFifoInReady;
   logic          rxFifoOutValid;
   logic [DW-1:0] rxFifoOutData;
   logic          rxFifoPop;
   logic          overrunEvent;
   logic          rxReadyNow;
   logic [DW-1:0] rxHeadNow;
   logic          rxFifoPush;

   // transmit path
   logic [DW-1:0] txHold;
   logic          txHoldFull;
   logic          txFifoInReady;
   logic          txFifoOutValid;
   logic [DW-1:0] txFifoOutData;
   logic          txFifoPop;
   logic          txOutFree;
   logic          txEmptyNow;
   logic          txFifoPush;
   logic          txLoadFifo;
   logic          txLoadHold;

   logic          flushFifos;
   logic [31:0]   next_prdata;
   logic          next_pslverr;
   logic [31:0]   dataWord;
   logic [31:0]   ctrlWord;
   logic [31:0]   statusWord;

   // one aligned word per alias, all sixteen land on the same data path
   assign aliasOffset = paddr - usdp_pkg::ALIAS_BASE;
   assign isAlias     = (aliasOffset < usdp_pkg::ALIAS_SPAN)
                        && (paddr[1:0] == 2'b00);
   assign isCtrl      = (paddr == usdp_pkg::CTRL_ADDR);
   assign isStatus    = (paddr == usdp_pkg::STATUS_ADDR);

   // side effects fire once, in the cycle before pready rises
   assign access      = psel & penable & ~pready;
   assign dataRead    = access & ~pwrite & isAlias;
   assign dataWrite   = access &  pwrite & isAlias;
   assign ctrlWrite   = access &  pwrite & isCtrl;
   assign statusRead  = access & ~pwrite & isStatus;

   // receiver selected by the infrared mode bit
   assign rxValid = irMode ? rxIrValid : rxSerialValid;
   assign rxData  = irMode ? rxIrData  : rxSerialData;

   assign rxFifoPop  = dataRead & fifoEnable;
   assign rxReadyNow = fifoEnable ? rxFifoOutValid : rxHoldFull;
   assign rxHeadNow  = fifoEnable ? rxFifoOutData  : rxHold;

   // a read in the same cycle frees the holding slot, so no overrun then
   assign overrunEvent = rxValid &
      (fifoEnable ? ~rxFifoInReady
                  : (rxHoldFull & ~dataRead));

   assign txOutFree  = ~txCharValid | txCharReady;
   assign txFifoPop  = fifoEnable & txOutFree;
   assign txEmptyNow = fifoEnable ? ~txFifoOutValid : ~txHoldFull;
   assign txLoadFifo = fifoEnable & txFifoOutValid;
   assign txLoadHold = ~fifoEnable & txHoldFull & ~flushFifos;

   // only the active mode feeds a fifo
   assign rxFifoPush = rxValid & fifoEnable;
   assign txFifoPush = dataWrite & fifoEnable;

   usdp_fifo #(
      .WIDTH (DW),
      .DEPTH (usdp_pkg::FIFO_DEPTH)
   ) rxFifo (
      .clk      (clk),
      .rst      (rst),
      .flush    (flushFifos),
      .inValid  (rxFifoPush),
      .inData   (rxData),
      .inReady  (rxFifoInReady),
      .outValid (rxFifoOutValid),
      .outData  (rxFifoOutData),
      .outReady (rxFifoPop)
   );

   // a full fifo refuses the push, so extra writes vanish
   usdp_fifo #(
      .WIDTH (DW),
      .DEPTH (usdp_pkg::FIFO_DEPTH)
   ) txFifo (
      .clk      (clk),
      .rst      (rst),
      .flush    (flushFifos),
      .inValid  (txFifoPush),
      .inData   (pwdata[DW-1:0]),
      .inReady  (txFifoInReady),
      .outValid (txFifoOutValid),
      .outData  (txFifoOutData),
      .outReady (txFifoPop)
   );

   // read words per register, upper bits of the data word always zero
   always_comb begin
      dataWord         = usdp_pkg::DATA_RESET;
      dataWord[DW-1:0] = rxHeadNow;
   end

   always_comb begin
      ctrlWord                         = usdp_pkg::DATA_RESET;
      ctrlWord[usdp_pkg::CTRL_FIFO_EN] = fifoEnable;
      ctrlWord[usdp_pkg::CTRL_IR_MODE] = irMode;
   end

   always_comb begin
      statusWord                          = usdp_pkg::DATA_RESET;
      statusWord[usdp_pkg::STAT_RX_READY] = rxReadyNow;
      statusWord[usdp_pkg::STAT_OVERRUN]  = overrunError;
      statusWord[usdp_pkg::STAT_RX_FULL]  = ~rxFifoInReady;
      statusWord[usdp_pkg::STAT_TX_EMPTY] = txEmptyNow;
      statusWord[usdp_pkg::STAT_TX_FULL]  = ~txFifoInReady;
   end

   // writes answer zero; an unmapped address answers with an error only
   always_comb begin
      next_prdata  = usdp_pkg::DATA_RESET;
      next_pslverr = 1'b0;
      if (!(isAlias || isCtrl || isStatus)) begin
         next_pslverr = 1'b1;
      end else if (!pwrite) begin
         if (isAlias) begin
            next_prdata = dataWord;
         end else if (isCtrl) begin
            next_prdata = ctrlWord;
         end else begin
            next_prdata = statusWord;
         end
      end
   end

   // one wait state on every transfer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (access) begin
         pready  <= 1'b1;
         pslverr <= next_pslverr;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // read data stands only in the answer cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= usdp_pkg::DATA_RESET;
      end else if (access) begin
         prdata <= next_prdata;
      end else begin
         prdata <= usdp_pkg::DATA_RESET;
      end
   end

   // control register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fifoEnable <= usdp_pkg::CTRL_FIFO_EN_RESET;
         irMode     <= usdp_pkg::CTRL_IR_MODE_RESET;
      end else if (ctrlWrite) begin
         fifoEnable <= pwdata[usdp_pkg::CTRL_FIFO_EN];
         irMode     <= pwdata[usdp_pkg::CTRL_IR_MODE];
      end
   end

   // a change of fifo mode empties both fifos and both holding slots
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flushFifos <= 1'b0;
      end else begin
         flushFifos <= ctrlWrite
                       && (pwdata[usdp_pkg::CTRL_FIFO_EN] != fifoEnable);
      end
   end

   // receive holding byte for fifo-less mode, overwritten by each arrival
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxHold <= '0;
      end else if (!flushFifos && !fifoEnable && rxValid) begin
         rxHold <= rxData;
      end
   end

   // receive holding flag; a new byte wins over a read in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxHoldFull <= 1'b0;
      end else if (flushFifos) begin
         rxHoldFull <= 1'b0;
      end else if (!fifoEnable) begin
         if (rxValid) begin
            rxHoldFull <= 1'b1;
         end else if (dataRead) begin
            rxHoldFull <= 1'b0;
         end
      end
   end

   // sticky overrun, cleared by reading status; a new event wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         overrunError <= 1'b0;
      end else if (overrunEvent) begin
         overrunError <= 1'b1;
      end else if (statusRead) begin
         overrunError <= 1'b0;
      end
   end

   // transmit holding byte; an unsent byte is simply replaced
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txHold <= '0;
      end else if (!flushFifos && !fifoEnable && dataWrite) begin
         txHold <= pwdata[DW-1:0];
      end
   end

   // transmit holding flag for fifo-less mode
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txHoldFull <= 1'b0;
      end else if (flushFifos) begin
         txHoldFull <= 1'b0;
      end else if (!fifoEnable) begin
         if (dataWrite) begin
            txHoldFull <= 1'b1;
         end else if (txOutFree) begin
            txHoldFull <= 1'b0;
         end
      end
   end

   // output stage valid, held while the shifter stalls
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txCharValid <= 1'b0;
      end else if (txOutFree) begin
         txCharValid <= txLoadFifo | txLoadHold;
      end
   end

   // output stage byte, loaded only when a new byte is taken
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txCharData <= '0;
      end else if (txOutFree && txLoadFifo) begin
         txCharData <= txFifoOutData;
      end else if (txOutFree && txLoadHold) begin
         txCharData <= txHold;
      end
   end

   // receive status to the line status logic, one cycle behind
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxDataReady <= 1'b0;
      end else begin
         rxDataReady <= rxReadyNow;
      end
   end

   // transmit status resets to empty so software may write at once
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txHoldingEmpty <= 1'b1;
      end else begin
         txHoldingEmpty <= txEmptyNow;
      end
   end
endmodule

/* File: tb/uart_shadow_data_port_tb.sv */
// self-checking bench for the shadow data port
`timescale 1ns/1ps
module uart_shadow_data_port_tb;
   localparam logic [31:0] ST = usdp_pkg::STATUS_ADDR;
   localparam logic [31:0] CT = usdp_pkg::CTRL_ADDR;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, stall;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic        rxSerialValid, rxIrValid, txCharValid, txCharReady, err;
   logic [7:0]  rxSerialData, rxIrData, txCharData;
   logic        irMode, fifoEnable, rxDataReady, txHoldingEmpty, overrunError;
   int          n_mismatch = 0;
   int          checked = 0;
   usdp_shadow_port i_dut (.*);
   usdp_far_model i_far (.*);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   function automatic logic [31:0] al(int i);
      return usdp_pkg::ALIAS_BASE + 32'(4 * i);
   endfunction
   task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_mismatch++;
         report_and_stop;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdx(logic [31:0] a, logic [31:0] e);
      apb(1'b0, a, '0);
      chk("prdata", rd, e);
   endtask
   task automatic s_reset;
      chk("thempty", txHoldingEmpty, 1'b1);
      rdx(al(14), '0);
      rdx(CT, '0);
      apb(1'b0, 32'h5000_1170, '0);
      chk("slverr", err, 1'b1);
      chk("errdata", rd, '0);
   endtask
   task automatic s_rx_hold;
      i_far.send(1'b1, 8'h77);
      tick(2);
      chk("ready", rxDataReady, 1'b0);
      i_far.send(1'b0, 8'hA5);
      tick(2);
      chk("ready", rxDataReady, 1'b1);
      i_far.send(1'b0, 8'h3C);
      tick(2);
      chk("overrun", overrunError, 1'b1);
      rdx(al(7), 32'h3C);
      rdx(ST, 32'h22);
      chk("overrun", overrunError, 1'b0);
      apb(1'b1, CT, 32'h2);
      chk("irmode", irMode, 1'b1);
      i_far.send(1'b1, 8'h5A);
      i_far.send(1'b0, 8'hFF);
      tick(2);
      rdx(al(15), 32'h5A);
   endtask
   // writes while not empty on purpose: the replace path is the point
   task automatic s_tx_hold;
      chk("thempty", txHoldingEmpty, 1'b1);
      stall <= 1'b1;
      apb(1'b1, al(3), 32'hFFFF_FF11);
      apb(1'b1, al(4), 32'h22);
      tick(1);
      chk("thempty", txHoldingEmpty, 1'b0);
      apb(1'b1, al(5), 32'h33);
      stall <= 1'b0;
      tick(6);
      chk("txcount", i_far.got.size(), 2);
      chk("txbyte", i_far.got[0], 32'h11);
      chk("txbyte", i_far.got[1], 32'h33);
      i_far.got.delete();
   endtask
   task automatic s_fifo;
      apb(1'b1, CT, 32'h1);
      chk("fifoen", fifoEnable, 1'b1);
      stall <= 1'b1;
      for (int i = 0; i < 17; i++) apb(1'b1, al(i % 16), 32'h40 + i);
      apb(1'b1, al(0), 32'hEE);
      rdx(ST, 32'h40);
      stall <= 1'b0;
      tick(60);
      chk("txcount", i_far.got.size(), 17);
      for (int i = 0; i < 17; i++) begin
         chk("txbyte", i_far.got[i], 32'h40 + i);
      end
      chk("thempty", txHoldingEmpty, 1'b1);
      for (int i = 0; i < 17; i++) i_far.send(1'b0, 8'h80 + i[7:0]);
      tick(2);
      rdx(ST, 32'h27);
      for (int i = 0; i < 16; i++) rdx(al(i), 32'h80 + i);
      chk("ready", rxDataReady, 1'b0);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      stall = 1'b0;
      tick(4);
      rst <= 1'b0;
      tick(1);
      s_reset;
      s_rx_hold;
      s_tx_hold;
      s_fifo;
      report_and_stop;
   end
   // about six times the expected run
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop;
   end
endmodule

/* File: tb/usdp_far_model.sv */
// remote serial end: sends rx bytes, takes tx bytes
`timescale 1ns/1ps
module usdp_far_model (
   input  wire logic       clk,
   input  wire logic       stall,
   input  wire logic       txCharValid,
   input  wire logic [7:0] txCharData,
   output logic            txCharReady,
   output logic            rxSerialValid,
   output logic      [7:0] rxSerialData,
   output logic            rxIrValid,
   output logic      [7:0] rxIrData
);
   logic [7:0] got[$];
   initial begin
      rxSerialValid = 1'b0;
      rxIrValid = 1'b0;
      rxSerialData = 8'h00;
      rxIrData = 8'h00;
   end
   // a slow shifter is modelled by holding ready low
   assign txCharReady = !stall;
   always @(posedge clk) begin
      if (txCharValid && txCharReady)
         got.push_back(txCharData);
   end
   // one pulse on the chosen input; idle data shows the inverse
   task automatic send(input bit ir, input logic [7:0] b);
      @(posedge clk);
      rxIrValid <= ir;
      rxSerialValid <= !ir;
      rxIrData <= b;
      rxSerialData <= b;
      @(posedge clk);
      rxIrValid <= 1'b0;
      rxSerialValid <= 1'b0;
      rxIrData <= ~b;
      rxSerialData <= ~b;
   endtask
endmodule

/* File: tb/usdp_shadow_port_assertions.sv */
// concurrent checks on the shadow data port pins
`timescale 1ns/1ps
module usdp_chk (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        rxSerialValid,
   input wire logic        rxIrValid,
   input wire logic        txCharValid,
   input wire logic [7:0]  txCharData,
   input wire logic        txCharReady,
   input wire logic        irMode,
   input wire logic        fifoEnable,
   input wire logic        rxDataReady,
   input wire logic        overrunError
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic take;
   logic rd;
   logic ctl;
   logic rxIn;
   assign take = psel && penable && !pready;
   assign rd = take && !pwrite;
   assign ctl = take && pwrite && paddr == usdp_pkg::CTRL_ADDR;
   assign rxIn = irMode ? rxIrValid : rxSerialValid;
   a_one_wait: assert property (take |=> pready)
      else $error("no answer after access phase");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   a_err_quiet: assert property (pslverr |-> pready && prdata == '0)
      else $error("error answer carries data");
   a_tx_held: assert property (txCharValid && !txCharReady
      |=> txCharValid && $stable(txCharData))
      else $error("tx byte changed while stalled");
   a_ctrl_fifo: assert property (ctl && !pwdata[0] |-> ##[1:2] !fifoEnable)
      else $error("fifo enable not cleared");
   a_ctrl_ir: assert property (ctl && pwdata[1] |-> ##[1:2] irMode)
      else $error("infrared mode not set");
   a_overrun_keep: assert property (overrunError && !rd |=> overrunError)
      else $error("overrun dropped without read");
   a_overrun_set: assert property (!fifoEnable && !$past(fifoEnable)
      && !$past(fifoEnable, 2) && rxDataReady && !$past(rd) && rxIn && !rd
      |=> overrunError)
      else $error("overwrite without overrun");
   c_err: cover property (pslverr);
   c_over: cover property (rxIn && rxDataReady && !fifoEnable);
   c_stall: cover property (txCharValid && !txCharReady ##1 txCharReady);
endmodule
bind usdp_shadow_port usdp_chk i_chk (.*);
